// >>> src/event_latch.sv
// sticky event flags, one latch per bit
`timescale 1ns/1ns
`default_nettype none

module event_latch (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] set_i,
    input  wire logic       clear_i,
    output var  logic [7:0] flags_o
);

    // ------------------------------------------------------------------
    // per bit latch
    // ------------------------------------------------------------------
    // set wins over clear so an event in the clearing cycle survives
    for (genvar i = 0; i < status_pkg::REG_W; i++) begin : g_bit
        always_ff @(posedge clk_sys_i) begin
            if (reset_i) begin
                flags_o[i] <= status_pkg::ESR_RESET[i];
            end else if (set_i[i]) begin
                flags_o[i] <= 1'b1;
            end else if (clear_i) begin
                flags_o[i] <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// >>> src/status_pkg.sv
// constants, command codes and carrier types of the status reporting block
package status_pkg;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned REG_W     = 8;
    localparam logic [7:0]  SRE_RESET = 8'h00;
    localparam logic [7:0]  ESE_RESET = 8'h00;
    // power-on flag is raised by reset itself
    localparam logic [7:0]  ESR_RESET = 8'h80;
    localparam logic [7:0]  STB_RESET = 8'h00;
    localparam logic [7:0]  OPC_REPLY = 8'h01;

    // ------------------------------------------------------------------
    // field positions of the status byte
    // ------------------------------------------------------------------
    localparam int unsigned STB_ERRQ_BIT = 2;
    localparam int unsigned STB_QUES_BIT = 3;
    localparam int unsigned STB_MAV_BIT  = 4;
    localparam int unsigned STB_ESB_BIT  = 5;
    localparam int unsigned STB_MSS_BIT  = 6;

    // ------------------------------------------------------------------
    // field positions of the standard event flags
    // ------------------------------------------------------------------
    localparam int unsigned ESR_OPC_BIT = 0;
    localparam int unsigned ESR_PON_BIT = 7;

    // ------------------------------------------------------------------
    // commands, states and carriers
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE   = 4'h0,
        CMD_SRE_WR = 4'h1,
        CMD_SRE_RD = 4'h2,
        CMD_STB_RD = 4'h3,
        CMD_ESE_WR = 4'h4,
        CMD_ESE_RD = 4'h5,
        CMD_ESR_RD = 4'h6,
        CMD_CLS    = 4'h7,
        CMD_OPC    = 4'h8,
        CMD_OPC_RD = 4'h9
    } cmd_op_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_OPC_WAIT = 3'b010,
        ST_OPQ_WAIT = 3'b100
    } state_t;

    typedef struct packed {
        logic       valid;
        cmd_op_t    op;
        logic [7:0] value;
    } cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reply_t;

endpackage

// >>> src/status_report.sv
// status byte, service request mask and standard event register bank
`timescale 1ns/1ns
`default_nettype none

module status_report (
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire status_pkg::cmd_t   cmd_i,
    output var  logic               cmd_ready_o,
    output var  status_pkg::reply_t reply_o,
    input  wire logic [7:0]         std_event_i,
    input  wire logic               pending_i,
    input  wire logic               errq_nonempty_i,
    input  wire logic               ques_summary_i,
    input  wire logic               msg_avail_i,
    output var  logic [7:0]         status_byte_o,
    output var  logic               group_clear_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    status_pkg::state_t state_r;
    status_pkg::state_t state_nxt;
    status_pkg::reply_t reply_r;
    status_pkg::reply_t reply_nxt;
    logic [7:0]         sre_r;
    logic [7:0]         ese_r;
    logic [7:0]         stb_r;
    logic               ready_r;
    logic               clr_r;
    logic [7:0]         esr_w;

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire       take      = cmd_i.valid & ready_r;
    wire       is_sre_wr = take & (cmd_i.op == status_pkg::CMD_SRE_WR);
    wire       is_sre_rd = take & (cmd_i.op == status_pkg::CMD_SRE_RD);
    wire       is_stb_rd = take & (cmd_i.op == status_pkg::CMD_STB_RD);
    wire       is_ese_wr = take & (cmd_i.op == status_pkg::CMD_ESE_WR);
    wire       is_ese_rd = take & (cmd_i.op == status_pkg::CMD_ESE_RD);
    wire       is_esr_rd = take & (cmd_i.op == status_pkg::CMD_ESR_RD);
    wire       is_cls    = take & (cmd_i.op == status_pkg::CMD_CLS);
    wire       is_opc    = take & (cmd_i.op == status_pkg::CMD_OPC);
    wire       is_opc_rd = take & (cmd_i.op == status_pkg::CMD_OPC_RD);
    wire       opc_done  = (state_r == status_pkg::ST_OPC_WAIT) & ~pending_i;
    wire       opq_done  = (state_r == status_pkg::ST_OPQ_WAIT) & ~pending_i;
    wire       esr_clear = is_cls | is_esr_rd;
    wire [7:0] opc_set   = opc_done ? (8'h01 << status_pkg::ESR_OPC_BIT)
                                    : 8'h00;
    wire [7:0] esr_set   = std_event_i | opc_set;

    // ------------------------------------------------------------------
    // status byte summary
    // ------------------------------------------------------------------
    // summary is rebuilt every cycle, so clearing the events clears it too
    wire [7:0] mss_mask = 8'h01 << status_pkg::STB_MSS_BIT;
    wire       esb      = |(esr_w & ese_r);
    wire [7:0] stb_base;
    assign stb_base[0]                        = 1'b0;
    assign stb_base[1]                        = 1'b0;
    assign stb_base[status_pkg::STB_ERRQ_BIT] = errq_nonempty_i;
    assign stb_base[status_pkg::STB_QUES_BIT] = ques_summary_i;
    assign stb_base[status_pkg::STB_MAV_BIT]  = msg_avail_i;
    assign stb_base[status_pkg::STB_ESB_BIT]  = esb;
    assign stb_base[status_pkg::STB_MSS_BIT]  = 1'b0;
    assign stb_base[7]                        = 1'b0;
    wire       master_summary_flag      = |(stb_base & sre_r & ~mss_mask);
    wire [7:0] stb_nxt  = stb_base | (master_summary_flag ? mss_mask : 8'h00);

    // ------------------------------------------------------------------
    // standard event flags
    // ------------------------------------------------------------------
    event_latch event_latch_inst (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .set_i     (esr_set),
        .clear_i   (esr_clear),
        .flags_o   (esr_w)
    );

    // ------------------------------------------------------------------
    // sequencing and replies
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            status_pkg::ST_IDLE: begin
                if (is_opc) begin
                    state_nxt = status_pkg::ST_OPC_WAIT;
                end else if (is_opc_rd) begin
                    state_nxt = status_pkg::ST_OPQ_WAIT;
                end
            end
            status_pkg::ST_OPC_WAIT: begin
                if (!pending_i) begin
                    state_nxt = status_pkg::ST_IDLE;
                end
            end
            status_pkg::ST_OPQ_WAIT: begin
                if (!pending_i) begin
                    state_nxt = status_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = status_pkg::ST_IDLE;
            end
        endcase
    end

    // the stored byte is returned; decimal text is the formatter's job
    always_comb begin
        reply_nxt.valid = is_sre_rd | is_stb_rd | is_ese_rd | is_esr_rd
                        | opq_done;
        reply_nxt.data  = 8'h00;
        if (is_sre_rd) begin
            reply_nxt.data = sre_r;
        end else if (is_stb_rd) begin
            reply_nxt.data = stb_r;
        end else if (is_ese_rd) begin
            reply_nxt.data = ese_r;
        end else if (is_esr_rd) begin
            reply_nxt.data = esr_w;
        end else if (opq_done) begin
            reply_nxt.data = status_pkg::OPC_REPLY;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_r <= status_pkg::ST_IDLE;
            reply_r <= '0;
            ready_r <= 1'b0;
            clr_r   <= 1'b0;
            stb_r   <= status_pkg::STB_RESET;
        end else begin
            state_r <= state_nxt;
            reply_r <= reply_nxt;
            ready_r <= (state_nxt == status_pkg::ST_IDLE);
            clr_r   <= is_cls;
            stb_r   <= stb_nxt;
        end
    end

    // ------------------------------------------------------------------
    // masks
    // ------------------------------------------------------------------
    // plain binary weighting, no value outside 0 to 255 fits the port
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sre_r <= status_pkg::SRE_RESET;
            ese_r <= status_pkg::ESE_RESET;
        end else begin
            if (is_sre_wr) begin
                sre_r <= cmd_i.value;
            end
            if (is_ese_wr) begin
                ese_r <= cmd_i.value;
            end
        end
    end

    assign cmd_ready_o   = ready_r;
    assign reply_o       = reply_r;
    assign status_byte_o = stb_r;
    assign group_clear_o = clr_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_sre_store;
        is_sre_wr |=> sre_r == $past(cmd_i.value);
    endproperty
    a_sre_store: assert property (p_sre_store)
        else $error("service request mask not stored");

    property p_sre_weight;
        is_sre_wr && cmd_i.value == 8'h07
            |=> sre_r[2:0] == 3'h7 && sre_r[7:3] == 5'h00;
    endproperty
    a_sre_weight: assert property (p_sre_weight)
        else $error("mask weighting wrong");

    property p_sre_query;
        is_sre_rd |=> reply_r.valid && reply_r.data == $past(sre_r)
            && sre_r == $past(sre_r);
    endproperty
    a_sre_query: assert property (p_sre_query)
        else $error("mask query wrong");

    property p_stb_query;
        is_stb_rd && stb_r[status_pkg::STB_MSS_BIT] && !esr_clear
            |=> reply_r.data == $past(stb_r)
            && reply_r.data[status_pkg::STB_MSS_BIT];
    endproperty
    a_stb_query: assert property (p_stb_query)
        else $error("status byte query wrong");

    property p_stb_poll;
        reply_r.valid && $past(is_stb_rd)
            |-> reply_r.data == $past(status_byte_o);
    endproperty
    a_stb_poll: assert property (p_stb_poll)
        else $error("status query differs from poll byte");

    property p_ese;
        is_ese_wr ##2 is_ese_rd |=> reply_r.data == $past(cmd_i.value, 3);
    endproperty
    a_ese: assert property (p_ese)
        else $error("event mask readback wrong");

    property p_ese_store;
        is_ese_wr |=> ese_r == $past(cmd_i.value);
    endproperty
    a_ese_store: assert property (p_ese_store)
        else $error("event mask not stored");

    property p_ese_query;
        is_ese_rd |=> reply_r.valid && reply_r.data == $past(ese_r)
            && ese_r == $past(ese_r);
    endproperty
    a_ese_query: assert property (p_ese_query)
        else $error("event mask query wrong");

    property p_esr_query;
        is_esr_rd && std_event_i == 8'h00
            |=> reply_r.data == $past(esr_w) && esr_w == 8'h00;
    endproperty
    a_esr_query: assert property (p_esr_query)
        else $error("event register query or clear wrong");

    property p_cls;
        is_cls && std_event_i == 8'h00 |=> esr_w == 8'h00 && group_clear_o;
    endproperty
    a_cls: assert property (p_cls)
        else $error("clear status incomplete");

    property p_opc;
        state_r == status_pkg::ST_OPC_WAIT && !pending_i
            |=> esr_w[status_pkg::ESR_OPC_BIT] && ready_r;
    endproperty
    a_opc: assert property (p_opc)
        else $error("operation complete bit not set");

    property p_opq;
        state_r == status_pkg::ST_OPQ_WAIT
            |=> reply_r.valid == !$past(pending_i)
            && (!reply_r.valid || reply_r.data == status_pkg::OPC_REPLY);
    endproperty
    a_opq: assert property (p_opq)
        else $error("completion reply wrong");

    property p_wait_ready;
        is_opc || is_opc_rd |=> !ready_r;
    endproperty
    a_wait_ready: assert property (p_wait_ready)
        else $error("ready not dropped during completion wait");

    property p_mss;
        ##1 stb_r[status_pkg::STB_MSS_BIT] == $past(
            (errq_nonempty_i & sre_r[status_pkg::STB_ERRQ_BIT])
            | (ques_summary_i & sre_r[status_pkg::STB_QUES_BIT])
            | (msg_avail_i & sre_r[status_pkg::STB_MAV_BIT])
            | (|(esr_w & ese_r) & sre_r[status_pkg::STB_ESB_BIT]));
    endproperty
    a_mss: assert property (p_mss)
        else $error("master summary wrong");

    property p_sticky;
        !esr_clear |=> (esr_w & $past(esr_w)) == $past(esr_w);
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event flag lost");

    property p_esb;
        ##1 stb_r[status_pkg::STB_ESB_BIT] == $past(|(esr_w & ese_r));
    endproperty
    a_esb: assert property (p_esb)
        else $error("event summary wrong");

    c_opc: cover property (is_opc ##[1:20] esr_w[status_pkg::ESR_OPC_BIT]);
    c_opq: cover property (is_opc_rd ##[1:20] reply_r.valid);
    c_mss: cover property (is_sre_wr ##[1:10] stb_r[status_pkg::STB_MSS_BIT]);
    c_esr: cover property (is_esr_rd && esr_w != 8'h00);
    c_cls: cover property (is_cls ##1 group_clear_o);

endmodule
`default_nettype wire

// >>> verification/host_model.sv
// remote controller model issuing status commands one at a time
`timescale 1ns/1ns
`default_nettype none

module host_model (
    input  wire logic               clk_sys_i,
    input  wire logic               cmd_ready_i,
    input  wire status_pkg::reply_t reply_i,
    output var  status_pkg::cmd_t   cmd_o
);
    // ------------------------------------------------------------------
    // command issue
    // ------------------------------------------------------------------
    initial cmd_o = '0;

    // value field is inverted once released so stale data never matches
    task automatic issue(input status_pkg::cmd_op_t op,
                         input logic [7:0] val, input int lim,
                         output logic [7:0] data, output int waited);
        logic rdy;
        data   = 8'hXX;
        waited = 0;
        @(posedge clk_sys_i);
        cmd_o <= '{valid: 1'b1, op: op, value: val};
        do begin
            @(negedge clk_sys_i);
            rdy = cmd_ready_i;
            @(posedge clk_sys_i);
        end while (rdy !== 1'b1);
        cmd_o <= '{valid: 1'b0, op: status_pkg::CMD_NONE, value: ~val};
        while (waited < lim) begin
            @(negedge clk_sys_i);
            waited++;
            if (reply_i.valid === 1'b1) begin
                data = reply_i.data;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/instrument_status_reporting_tb.sv
// self-checking testbench of the status reporting block
`timescale 1ns/1ns
`default_nettype none

module instrument_status_reporting_tb;
    logic               clk_sys_i = 1'b0;
    logic               reset_i   = 1'b1;
    status_pkg::cmd_t   cmd;
    logic               ready;
    status_pkg::reply_t reply;
    logic [7:0]         std_event = 8'h00;
    logic               pending   = 1'b0;
    logic               errq      = 1'b0;
    logic               ques      = 1'b0;
    logic               msg       = 1'b0;
    logic [7:0]         stb;
    logic               gclr;
    logic [7:0]         gclr_cnt  = 8'h00;
    logic [7:0]         d;
    int                 w;
    int                 errors    = 0;
    int                 num_checks = 0;

    always #10 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (gclr === 1'b1) begin
            gclr_cnt <= gclr_cnt + 8'h01;
        end
    end

    status_report status_report_inst (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cmd_i(cmd),
        .cmd_ready_o(ready), .reply_o(reply), .std_event_i(std_event),
        .pending_i(pending), .errq_nonempty_i(errq),
        .ques_summary_i(ques), .msg_avail_i(msg),
        .status_byte_o(stb), .group_clear_o(gclr));

    host_model host_model_inst (
        .clk_sys_i(clk_sys_i), .cmd_ready_i(ready), .reply_i(reply),
        .cmd_o(cmd));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input status_pkg::cmd_op_t op, input logic [7:0] exp);
        host_model_inst.issue(op, 8'h00, 4, d, w);
        chk(d, exp);
    endtask

    task automatic wr(input status_pkg::cmd_op_t op, input logic [7:0] v);
        host_model_inst.issue(op, v, 0, d, w);
    endtask

    // status byte lags its inputs, so let it settle before sampling
    task automatic chk_stb(input logic [7:0] exp);
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(stb, exp);
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge clk_sys_i) std_event <= v;
        @(posedge clk_sys_i) std_event <= 8'h00;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rd(status_pkg::CMD_ESR_RD, 8'h80);
        rd(status_pkg::CMD_ESR_RD, 8'h00);
        rd(status_pkg::CMD_SRE_RD, 8'h00);
        rd(status_pkg::CMD_ESE_RD, 8'h00);
        $display("test reset done");
        wr(status_pkg::CMD_SRE_WR, 8'h07);
        rd(status_pkg::CMD_SRE_RD, 8'h07);
        rd(status_pkg::CMD_SRE_RD, 8'h07);
        wr(status_pkg::CMD_SRE_WR, 8'hFF);
        rd(status_pkg::CMD_SRE_RD, 8'hFF);
        wr(status_pkg::CMD_ESE_WR, 8'h41);
        rd(status_pkg::CMD_ESE_RD, 8'h41);
        $display("test masks done");
        wr(status_pkg::CMD_SRE_WR, 8'h10);
        @(posedge clk_sys_i) {msg, errq, ques} <= 3'b111;
        chk_stb(8'h5C);
        rd(status_pkg::CMD_STB_RD, 8'h5C);
        rd(status_pkg::CMD_STB_RD, 8'h5C);
        wr(status_pkg::CMD_SRE_WR, 8'h00);
        chk_stb(8'h1C);
        @(posedge clk_sys_i) {msg, errq, ques} <= 3'b000;
        $display("test status byte done");
        wr(status_pkg::CMD_ESE_WR, 8'h10);
        wr(status_pkg::CMD_SRE_WR, 8'h20);
        pulse(8'h10);
        chk_stb(8'h60);
        chk_stb(8'h60);
        rd(status_pkg::CMD_ESR_RD, 8'h10);
        chk_stb(8'h00);
        $display("test events done");
        pulse(8'h30);
        chk_stb(8'h60);
        w = gclr_cnt;
        wr(status_pkg::CMD_CLS, 8'h00);
        chk_stb(8'h00);
        chk(gclr_cnt - w[7:0], 8'h01);
        rd(status_pkg::CMD_ESR_RD, 8'h00);
        $display("test clear done");
        @(posedge clk_sys_i) pending <= 1'b1;
        wr(status_pkg::CMD_OPC, 8'h00);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({7'h00, ready}, 8'h00);
        @(posedge clk_sys_i) pending <= 1'b0;
        rd(status_pkg::CMD_ESR_RD, 8'h01);
        @(posedge clk_sys_i) pending <= 1'b1;
        fork
            host_model_inst.issue(status_pkg::CMD_OPC_RD, 8'h00, 40, d, w);
            begin
                repeat (10) @(posedge clk_sys_i);
                pending <= 1'b0;
            end
        join
        chk(d, status_pkg::OPC_REPLY);
        chk({7'h00, w >= 9}, 8'h01);
        $display("test completion done");
        finish_test;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        errors++;
        finish_test;
    end
endmodule
`default_nettype wire
